// File: core/irq_pulse_defs.svh
`ifndef IRQ_PULSE_DEFS_SVH
`define IRQ_PULSE_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define CLK_MHZ            200
`define IRQ_PULSE_US       100
`define IRQ_GAP_US         100
`define IRQ_REPEAT_MS      5
`define SDM_FILT_US        64
`define US_PER_MS          1000

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL           8'h00
`define REG_GRP_STAT       8'h04
`define REG_WAKE_STAT      8'h08
`define REG_STATE          8'h0C

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define CTRL_MASK_LSB      0
`define CTRL_REPEAT_BIT    6
`define CTRL_WAKE_LSB      7
`define CTRL_BRAKE_BIT     12
`define CTRL_RST           32'h00000FFF

// ----------------------------------------------------------------
// state register fields
// ----------------------------------------------------------------
`define STATE_FSM_LSB      0
`define STATE_LEVEL_BIT    3
`define STATE_SDM_BIT      4
`define STATE_REQ_BIT      5

// ----------------------------------------------------------------
// source group index, widths and excluded flags
// ----------------------------------------------------------------
`define GRP_N              6
`define GRP_SUPPLY         0
`define GRP_THERMAL        1
`define GRP_BUS            2
`define GRP_HIGHSIDE       3
`define GRP_BRIDGE         4
`define GRP_FRAME          5
`define WAKE_N             5
`define WAKE_BRAKE         4
`define SUP_W              8
`define THERM_W            8
`define BUS_W              4
`define HS_W               8
`define DRAIN_SOURCE_OVERVOLTAGE_FLAGS_W             6
`define BRK_W              3
`define TMR_W              2
`define SUP_EXCL_MASK      8'h0F
`define THERM_EXCL_MASK    8'h01
`define DATA_W             32

`endif

// File: core/irq_pulse_pkg.sv
`include "irq_pulse_defs.svh"

package irq_pulse_pkg;

    // device operating mode as reported by the mode state machine
    typedef enum logic [2:0]
    {
        MODE_INIT     = 3'h0,
        MODE_NORMAL   = 3'h1,
        MODE_STOP     = 3'h2,
        MODE_SLEEP    = 3'h3,
        MODE_RESTART  = 3'h4,
        MODE_FAILSAFE = 3'h5
    } dev_mode_e;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_LOW  = 3'b010,
        ST_GAP  = 3'b100
    } irq_state_e;

    // bit0 of supply: power-on, bits 1..3 core supply under/short/over
    typedef struct packed
    {
        logic [`SUP_W-1:0]   supply_flags;
        logic [`THERM_W-1:0] thermal_flags_reg;
        logic [`BUS_W-1:0]   bus_flags;
        logic [`HS_W-1:0]    highside_flags_reg;
        logic [`DRAIN_SOURCE_OVERVOLTAGE_FLAGS_W-1:0]  drain_source_overvoltage_flags;
        logic                frame_fail;
        logic                checksum_fail;
    } fault_src_s;

    typedef struct packed
    {
        logic                lin;
        logic                pin;
        logic [`TMR_W-1:0]   cyclic_wake_timers;
        logic [`BRK_W-1:0]   lowside_brake_detect_flags;
    } wake_src_s;

endpackage

// File: core/irq_pulse_gen.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "irq_pulse_defs.svh"
// Notes on behaviour
// RULE1: in normal and stop mode, drive output low for one pulse width, then release.
// RULE2: output stays high at least the minimum gap between two pulses.
// RULE3: interrupt logic never changes the device mode; no path back.
// RULE4: per-group mask register; a masked group cannot start a pulse.
// RULE5: groups: supply, thermal, bus, high-side, bridge, frame/checksum failure.
// RULE6: a wake event raises an interrupt only if that input is a wake source.
// RULE7: wake sources: bus, wake pin, cyclic timers, brake detect when enabled.
// RULE8: group and wake interrupts work together; either starts a pulse.
// RULE9: core supply faults, level-two shutdown and power-on never interrupt.
// RULE10: only frame and checksum failure cause periodic repeat pulses.
// RULE11: no pulses in restart, fail-safe or sleep mode.
// RULE12: entering stop with wake or brake status uncleared starts a pulse.
// RULE13: status is captured at each falling edge of the pulse.
// RULE14: captured status stays set until software clears it.
// RULE15: host may read status again after clearing to confirm it is gone.
// RULE16: a pending uncleared event keeps producing pulses periodically; the code repeats only for a captured frame/checksum status.
// RULE17: a software enable bit can switch the repeat pulses off.
// RULE18: events together or during a low pulse give one pulse only.
// RULE19: in init mode the pin is an input sensing development mode entry.
// RULE20: repeat period is nominally 5 ms.
// RULE21: development mode selection is filtered for 64 us.
// RULE22: pulse width, gap and repeat timed by counters on the local clock.
// RULE23: a clear-to-set source edge requests a pulse, deferred past the gap.

module irq_pulse_gen
    import irq_pulse_pkg::*;
#(
    parameter int unsigned ADDR_W     = 8,
    parameter int unsigned CNT_W      = 20,
    parameter int unsigned PULSE_CYC  = `IRQ_PULSE_US * `CLK_MHZ,
    parameter int unsigned GAP_CYC    = `IRQ_GAP_US * `CLK_MHZ,
    parameter int unsigned REPEAT_CYC = `IRQ_REPEAT_MS * `US_PER_MS * `CLK_MHZ,
    parameter int unsigned SDM_CYC    = `SDM_FILT_US * `CLK_MHZ
)
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [`DATA_W-1:0] pwdata,
    output logic      [`DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // sources and mode
    input  wire fault_src_s        fault_src,
    input  wire wake_src_s         wake_src,
    input  wire dev_mode_e         dev_mode,
    // interrupt pin
    input  wire logic              irq_n_in,
    output logic                   irq_n_out,
    output logic                   irq_n_oe_n,
    // development mode selection
    output logic                   sdm_select
);

    // ----------------------------------------------------------------
    // limits
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] PULSE_LIM  = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LIM    = CNT_W'(GAP_CYC - 1);
    localparam logic [CNT_W-1:0] REPEAT_LIM = CNT_W'(REPEAT_CYC - 1);
    localparam logic [CNT_W-1:0] SDM_LIM    = CNT_W'(SDM_CYC - 1);

    function automatic logic mode_active(input dev_mode_e m);
        mode_active = (m == MODE_NORMAL) || (m == MODE_STOP);
    endfunction

    function automatic logic mode_quiet(input dev_mode_e m);
        mode_quiet = (m == MODE_RESTART) || (m == MODE_FAILSAFE) || (m == MODE_SLEEP);
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [`DATA_W-1:0] ctrl_ff;
    logic [`GRP_N-1:0]  grp_stat_ff;
    logic [`WAKE_N-1:0] wake_stat_ff;
    logic [`GRP_N-1:0]  grp_prev_ff;
    logic [`WAKE_N-1:0] wake_prev_ff;
    dev_mode_e          mode_prev_ff;
    irq_state_e         state_ff;
    irq_state_e         nxt_state;
    logic [CNT_W-1:0]   tmr_ff;
    logic [CNT_W-1:0]   rep_ff;
    logic               req_ff;
    logic               irq_ff;
    logic               oe_n_ff;
    logic               pin_s1_ff;
    logic               pin_s2_ff;
    logic               pin_last_ff;
    logic [CNT_W-1:0]   sdm_cnt_ff;
    logic               sdm_ff;
    logic [`DATA_W-1:0] prdata_ff;
    logic               pready_ff;
    logic               pslverr_ff;
    logic [`GRP_N-1:0]  grp_now;
    logic [`WAKE_N-1:0] wake_now;
    logic [`GRP_N-1:0]  grp_mask;
    logic [`WAKE_N-1:0] wake_en;
    logic               new_event;
    logic               stop_entry;
    logic               repeat_due;
    logic               pulse_start;
    logic               apb_acc;
    logic               apb_wr;
    logic               addr_hit;
    logic [`GRP_N-1:0]  grp_clr;
    logic [`WAKE_N-1:0] wake_clr;

    // ----------------------------------------------------------------
    // source grouping
    // ----------------------------------------------------------------
    assign grp_mask = ctrl_ff[`CTRL_MASK_LSB +: `GRP_N];
    assign wake_en  = ctrl_ff[`CTRL_WAKE_LSB +: `WAKE_N];

    always_comb
    begin
        grp_now = '0;
        grp_now[`GRP_SUPPLY]   = |(fault_src.supply_flags & ~`SUP_W'(`SUP_EXCL_MASK));          // RULE5 RULE9
        grp_now[`GRP_THERMAL]  = |(fault_src.thermal_flags_reg & ~`THERM_W'(`THERM_EXCL_MASK)); // RULE5 RULE9
        grp_now[`GRP_BUS]      = |fault_src.bus_flags;                                          // RULE5
        grp_now[`GRP_HIGHSIDE] = |fault_src.highside_flags_reg;                                 // RULE5
        grp_now[`GRP_BRIDGE]   = |fault_src.drain_source_overvoltage_flags;                     // RULE5
        grp_now[`GRP_FRAME]    = fault_src.frame_fail | fault_src.checksum_fail;                // RULE5
    end

    always_comb
    begin
        wake_now = {(|wake_src.lowside_brake_detect_flags) & ctrl_ff[`CTRL_BRAKE_BIT],          // RULE7
                    wake_src.cyclic_wake_timers, wake_src.pin, wake_src.lin} & wake_en;         // RULE6
    end

    // clear-to-set edges of enabled sources only
    assign new_event  = |(grp_now & ~grp_prev_ff & grp_mask) | |(wake_now & ~wake_prev_ff); // RULE4 RULE8 RULE23
    assign stop_entry = (dev_mode == MODE_STOP) && (mode_prev_ff != MODE_STOP)
                        && ((|wake_stat_ff) || (|wake_src.lowside_brake_detect_flags));      // RULE12
    assign repeat_due = ctrl_ff[`CTRL_REPEAT_BIT] && grp_stat_ff[`GRP_FRAME]
                        && (rep_ff == REPEAT_LIM);                                           // RULE10 RULE16 RULE17

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_prev_ff  <= '0;
            wake_prev_ff <= '0;
            mode_prev_ff <= MODE_INIT;
        end
        else
        begin
            grp_prev_ff  <= grp_now;
            wake_prev_ff <= wake_now;
            mode_prev_ff <= dev_mode;
        end
    end

    // ----------------------------------------------------------------
    // pulse request
    // ----------------------------------------------------------------
    // requests arriving while low are dropped so overlapping events merge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            req_ff <= 1'b0;
        else if (!mode_active(dev_mode))
            req_ff <= 1'b0;                                                  // RULE11
        else if (pulse_start || state_ff == ST_LOW)
            req_ff <= 1'b0;                                                  // RULE18
        else if (new_event || stop_entry || repeat_due)
            req_ff <= 1'b1;                                                  // RULE23
    end

    // ----------------------------------------------------------------
    // pulse sequencer
    // ----------------------------------------------------------------
    assign pulse_start = (state_ff == ST_IDLE) && req_ff && mode_active(dev_mode);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (pulse_start) nxt_state = ST_LOW;
            ST_LOW:  if (tmr_ff == PULSE_LIM) nxt_state = ST_GAP;            // RULE1
            ST_GAP:  if (tmr_ff == GAP_LIM) nxt_state = ST_IDLE;             // RULE2
            default: nxt_state = ST_IDLE;
        endcase
        if (!mode_active(dev_mode))
            nxt_state = ST_IDLE;                                             // RULE11
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tmr_ff <= '0;
        else if (nxt_state != state_ff)
            tmr_ff <= '0;
        else if (state_ff != ST_IDLE)
            tmr_ff <= tmr_ff + 1'b1;                                         // RULE22
    end

    // repeat period measured from the start of each pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rep_ff <= '0;
        else if (pulse_start || !mode_active(dev_mode))
            rep_ff <= '0;
        else if (rep_ff != REPEAT_LIM)
            rep_ff <= rep_ff + 1'b1;                                         // RULE20 RULE22
    end

    // the block only reads dev_mode; nothing here feeds the mode machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_ff  <= 1'b1;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            irq_ff  <= (nxt_state != ST_LOW);                                // RULE1 RULE3
            oe_n_ff <= (dev_mode == MODE_INIT);                              // RULE19
        end
    end

    // ----------------------------------------------------------------
    // development mode sense
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end
        else
        begin
            pin_s1_ff <= irq_n_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // a pin held low externally against the pull-up selects the mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_last_ff <= 1'b1;
            sdm_cnt_ff  <= '0;
            sdm_ff      <= 1'b0;
        end
        else
        begin
            pin_last_ff <= pin_s2_ff;
            if (dev_mode != MODE_INIT || pin_s2_ff != pin_last_ff)
                sdm_cnt_ff <= '0;
            else if (sdm_cnt_ff != SDM_LIM)
                sdm_cnt_ff <= sdm_cnt_ff + 1'b1;
            if (dev_mode == MODE_INIT && sdm_cnt_ff == SDM_LIM)
                sdm_ff <= !pin_s2_ff;                                        // RULE19 RULE21
        end
    end

    // ----------------------------------------------------------------
    // apb slave and registers
    // ----------------------------------------------------------------
    assign apb_acc  = psel && penable && !pready_ff;
    assign apb_wr   = psel && penable && pready_ff && pwrite;
    assign addr_hit = (paddr == ADDR_W'(`REG_CTRL)) || (paddr == ADDR_W'(`REG_GRP_STAT))
                      || (paddr == ADDR_W'(`REG_WAKE_STAT)) || (paddr == ADDR_W'(`REG_STATE));
    assign grp_clr  = (apb_wr && paddr == ADDR_W'(`REG_GRP_STAT)) ? pwdata[`GRP_N-1:0] : '0;
    assign wake_clr = (apb_wr && paddr == ADDR_W'(`REG_WAKE_STAT)) ? pwdata[`WAKE_N-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_ff <= `CTRL_RST;
        else if (apb_wr && paddr == ADDR_W'(`REG_CTRL))
            ctrl_ff <= pwdata & (`CTRL_RST | (32'h1 << `CTRL_BRAKE_BIT));   // RULE4 RULE7 RULE17
    end

    // captured on the falling edge of the pulse; set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grp_stat_ff  <= '0;
            wake_stat_ff <= '0;
        end
        else
        begin
            grp_stat_ff  <= (grp_stat_ff & ~grp_clr) | (pulse_start ? (grp_now & grp_mask) : '0); // RULE13 RULE14
            wake_stat_ff <= (wake_stat_ff & ~wake_clr) | (pulse_start ? wake_now : '0);           // RULE13 RULE14
        end
    end

    // answer in the second access cycle, unmapped addresses flag an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else
        begin
            pready_ff  <= apb_acc;
            pslverr_ff <= apb_acc && !addr_hit;
            prdata_ff  <= '0;
            if (apb_acc && !pwrite)
            begin
                unique case (paddr)
                    ADDR_W'(`REG_CTRL):      prdata_ff <= ctrl_ff;
                    ADDR_W'(`REG_GRP_STAT):  prdata_ff <= `DATA_W'(grp_stat_ff);  // RULE15
                    ADDR_W'(`REG_WAKE_STAT): prdata_ff <= `DATA_W'(wake_stat_ff);
                    ADDR_W'(`REG_STATE):     prdata_ff <= `DATA_W'({req_ff, sdm_ff, irq_ff, state_ff});
                    default:                 prdata_ff <= '0;
                endcase
            end
        end
    end

    assign prdata     = prdata_ff;
    assign pready     = pready_ff;
    assign pslverr    = pslverr_ff;
    assign irq_n_out  = irq_ff;
    assign irq_n_oe_n = oe_n_ff;
    assign sdm_select = sdm_ff;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] low_len_ff;
    logic [CNT_W-1:0] high_len_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_len_ff  <= '0;
            high_len_ff <= '1;
        end
        else
        begin
            low_len_ff  <= irq_ff ? '0 : low_len_ff + 1'b1;
            high_len_ff <= !irq_ff ? '0 : (high_len_ff == '1 ? high_len_ff : high_len_ff + 1'b1);
        end
    end

    chk_pulse_width: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        $rose(irq_ff) && mode_active(dev_mode) && mode_active($past(dev_mode)) |-> low_len_ff == CNT_W'(PULSE_CYC))
        else $error("pulse width differs from nominal");
    chk_min_gap: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        $fell(irq_ff) |-> $past(high_len_ff) >= GAP_LIM)
        else $error("gap between pulses too short");
    chk_quiet_modes: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        mode_quiet(dev_mode) |=> irq_ff)
        else $error("pulse in restart, fail-safe or sleep");
    chk_init_release: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
        dev_mode == MODE_INIT |=> oe_n_ff && irq_ff)
        else $error("pin driven during init");
    chk_pulse_cause: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
        $fell(irq_ff) |-> $past(req_ff) && $past(state_ff) == ST_IDLE)
        else $error("pulse without request");
    chk_event_request: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        mode_active(dev_mode) && state_ff == ST_IDLE && new_event ##1 mode_active(dev_mode) |-> req_ff || !irq_ff)
        else $error("enabled event lost");
    chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        ##1 (($past(grp_stat_ff) & ~$past(grp_clr) & ~grp_stat_ff) == '0))
        else $error("status dropped without clear");
    chk_status_capture: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        pulse_start |=> ((grp_stat_ff & $past(grp_now & grp_mask)) == $past(grp_now & grp_mask)))
        else $error("status not captured on falling edge");
    chk_supply_excl: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        (fault_src.supply_flags & ~`SUP_W'(`SUP_EXCL_MASK)) == '0 |-> !grp_now[`GRP_SUPPLY])
        else $error("excluded supply flag raised group");
    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("apb answer not one cycle");
    cov_pulse:      cover property (@(posedge pclk) disable iff (!presetn) $fell(irq_ff));
    cov_repeat:     cover property (@(posedge pclk) disable iff (!presetn) repeat_due && !req_ff);
    cov_stop_entry: cover property (@(posedge pclk) disable iff (!presetn) stop_entry);
    cov_sdm:        cover property (@(posedge pclk) disable iff (!presetn) $rose(sdm_ff));

endmodule

// File: verif/host_model.sv
`timescale 1ns/100ps
// host side of the interrupt pin: counts finished pulses and flags bad widths or gaps
module host_model
#(
    parameter int PW = 20,
    parameter int GP = 20
)
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin
    input  wire logic irq_n_out,
    input  wire logic irq_n_oe_n,
    input  wire logic sdm_low,
    output logic      pin,
    // results
    output int        pulses,
    output int        bad
);
    int   lo;
    int   hi;
    logic seen;
    // pull-up keeps the pin high while nobody drives it
    assign pin = irq_n_oe_n ? !sdm_low : irq_n_out;
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pulses <= 0;
            bad <= 0;
            lo <= 0;
            hi <= 0;
            seen <= 0;
        end
        else if (!irq_n_oe_n && !pin)
        begin
            lo <= lo + 1;
            if (lo == 0 && seen && hi < GP)
                bad <= bad + 1;
        end
        else if (!irq_n_oe_n)
        begin
            hi <= (lo != 0) ? 1 : hi + 1;
            if (lo != 0)
            begin
                pulses <= pulses + 1;
                seen <= 1;
                lo <= 0;
                bad <= bad + int'(lo != PW);
            end
        end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
`include "irq_pulse_defs.svh"
module tb_top
    import irq_pulse_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sdm_low = 1;
    logic        pready, pslverr, irq_n_out, irq_n_oe_n, sdm_select, pin, er, m;
    logic [7:0]  paddr = '0, rng = 8'h5F;
    logic [31:0] pwdata = '0, prdata, rd;
    fault_src_s  fault_src = '0;
    wake_src_s   wake_src = '0;
    dev_mode_e   dev_mode = MODE_INIT;
    int          num_errors = 0, checked = 0, cyc = 0, pulses, bad, base, g;
    always #2.5 pclk = ~pclk;
    irq_pulse_gen #(.PULSE_CYC(20), .GAP_CYC(20), .REPEAT_CYC(200), .SDM_CYC(16)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fault_src(fault_src), .wake_src(wake_src),
        .dev_mode(dev_mode), .irq_n_in(pin), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n),
        .sdm_select(sdm_select));
    host_model host (.pclk(pclk), .presetn(presetn), .irq_n_out(irq_n_out),
        .irq_n_oe_n(irq_n_oe_n), .sdm_low(sdm_low), .pin(pin), .pulses(pulses), .bad(bad));
    // ------
    // helpers
    // ------
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // one flag of each group except frame/checksum; supply and thermal avoid their excluded low bits
    function automatic fault_src_s grp(input int k);
        int sh[5] = '{32, 21, 16, 8, 2};
        return fault_src_s'(36'(1) << sh[k]);
    endfunction
    task complete_run;
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] v);
        checked++;
        if (v !== e)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, v);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(n, e, rd);
    endtask
    // counts pulses that end inside the window
    task pulses_in(input int w, input int n);
        base = pulses;
        repeat (w) @(posedge pclk);
        chk("pulses", n, pulses - base);
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            num_errors++;
            complete_run;
        end
    end
    // ------
    // main sequence
    // ------
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        repeat (10) @(posedge pclk);
        chk("sdm_select", 0, sdm_select);
        repeat (30) @(posedge pclk);
        chk("sdm_select", 1, sdm_select);
        chk("irq_n_oe_n", 1, irq_n_oe_n);
        sdm_low <= 0;
        dev_mode <= MODE_NORMAL;
        rdchk("ctrl", `REG_CTRL, `CTRL_RST);
        rdchk("unmapped", 8'h10, 0);
        chk("pslverr", 1, er);
        repeat (4)
        begin
            rng = lfsr(rng);
            g = rng % 5;
            m = rng[7];
            apb(1, `REG_CTRL, m ? `CTRL_RST : `CTRL_RST & ~(32'h1 << g));
            fault_src <= grp(g);
            pulses_in(60, m);
            rdchk("grp_stat", `REG_GRP_STAT, 32'(m) << g);
            fault_src <= '0;
            apb(1, `REG_GRP_STAT, 32'h3F);
            rdchk("grp_stat", `REG_GRP_STAT, 0);
        end
        apb(1, `REG_CTRL, `CTRL_RST);
        fault_src <= fault_src_s'((36'hF << 28) | (36'h1 << 20));
        pulses_in(60, 0);
        fault_src <= grp(2);
        wake_src <= wake_src_s'(7'h40);
        repeat (10) @(posedge pclk);
        fault_src.highside_flags_reg <= 8'h01;
        pulses_in(290, 1);
        rdchk("grp_stat", `REG_GRP_STAT, 32'h04);
        rdchk("wake_stat", `REG_WAKE_STAT, 32'h01);
        fault_src <= '0;
        wake_src <= '0;
        apb(1, `REG_GRP_STAT, 32'h3F);
        dev_mode <= MODE_STOP;
        pulses_in(60, 1);
        apb(1, `REG_WAKE_STAT, 32'h1F);
        dev_mode <= MODE_NORMAL;
        fault_src.frame_fail <= 1;
        repeat (2) @(posedge pclk);
        fault_src.frame_fail <= 0;
        pulses_in(448, 3);
        apb(1, `REG_CTRL, `CTRL_RST & ~32'h40);
        pulses_in(450, 0);
        apb(1, `REG_GRP_STAT, 32'h20);
        apb(1, `REG_CTRL, 32'h00001EFF);
        wake_src <= wake_src_s'(7'h20);
        pulses_in(60, 0);
        wake_src <= wake_src_s'(7'h01);
        pulses_in(60, 1);
        rdchk("wake_stat", `REG_WAKE_STAT, 32'h10);
        dev_mode <= MODE_SLEEP;
        fault_src <= grp(2);
        pulses_in(60, 0);
        chk("irq_n_out", 1, irq_n_out);
        chk("host faults", 0, bad);
        complete_run;
    end
endmodule
